// ### cps_consts.vh
// Constants for the charger protection supervisor
`ifndef CPS_CONSTS_VH
`define CPS_CONSTS_VH
`define CPS_CLK_MHZ 250
`define CPS_OFF_CHG_CURRENT 8'h14
`define CPS_CHG_CURRENT_RST 16'h0000
`define CPS_CHG_CURRENT_MIN 16'h0080
`define CPS_CHG_CURRENT_MAX 16'h1F80
`define CPS_TRICKLE_MA 16'h00DC
`define CPS_LOW_LIMIT_MA 16'h0CE4
`define CPS_FIXED_OC_MA 16'h1388
`define CPS_SHORT_PAUSE_US 2000
`define CPS_SHORT_PAUSE_CYC (40'd2000 * 40'd250)
`define CPS_SS_STEP_US 1600
`define CPS_SS_STEP_CYC (40'd1600 * 40'd250)
`define CPS_SS_STEPS 4'h8
`define CPS_TIMEOUT_S 170
`define CPS_TIMEOUT_CYC (40'd170 * 40'd250000000)
`endif

// ### cps_step_timer.v
// Down counter that raises a pulse when a programmed count expires
`timescale 1ns/10ps
module cps_step_timer #(
	parameter WIDTH = 40
) (
	// Clock and reset
	input wire mclk,
	input wire rst_b,
	// Control
	input wire start,
	input wire [WIDTH-1:0] load_val,
	// Status
	output reg running_q,
	output reg done_q
);
	reg [WIDTH-1:0] cnt_q;
	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_q <= {WIDTH{1'b0}};
			running_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			done_q <= 1'b0;
			if (start) begin
				cnt_q <= load_val;
				running_q <= 1'b1;
			end else if (running_q) begin
				if (cnt_q <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
					running_q <= 1'b0;
					done_q <= 1'b1;
				end else begin
					cnt_q <= cnt_q - {{(WIDTH-1){1'b0}}, 1'b1};
				end
			end
		end
	end
endmodule

// ### cps_supervisor.v
// Charger protection and enable supervisor
`timescale 1ns/10ps
`include "cps_consts.vh"
// Function
// - Low-side off when charge sense below 10mV; clear at next cycle start.
// - High-side over 10A peak latches high-side off until next cycle.
// - Stop high-side while average current over 5A if programmed current below 3300mA, else over 145%; auto resume.
// - Inhibit switching above 104% setpoint, resume below 102%.
// - Output discharge sink enabled only while charging.
// - Battery below 3.6V flags short, halts 2ms, then soft-starts.
// - After short restart, 220mA trickle if battery below 2.5V, else programmed.
// - Hold trickle until battery above 2.7V, then use register 0x14 value.
// - Input current monitor grounded until supply over 4.5V and detect over 0.6V.
// - Bus accepted only with bus bias above 2.5V and reference valid.
// - Reference off below 4V; on when supply over 4.5V and detect over 0.6V.
// - Gate supply on with supply over 4.5V, detect over 2.4V, enable high.
// - Gate supply off during thermal shutdown.
// - Input alarm released while monitor below threshold, else pulled low.
// - Adapter-good released when detect above 2.4V, else pulled low.
// - Off above 155C until below 135C, then gate supply and soft-start.
// - Terminate if no voltage or current command within 170s; commands restart.
// - Ramp current limit to programmed value in eight 1.6ms steps.
// - Stop charging when any programmed setting is out of range.
module cps_supervisor #(
	parameter [39:0] SHORT_PAUSE_CYC = `CPS_SHORT_PAUSE_CYC,
	parameter [39:0] SS_STEP_CYC = `CPS_SS_STEP_CYC,
	parameter [39:0] TIMEOUT_CYC = `CPS_TIMEOUT_CYC
) (
	// Clock and reset
	input wire mclk,
	input wire rst_b,
	// Switching cycle timing
	input wire cycle_start,
	input wire lowside_on_req,
	input wire highside_on_req,
	// Protection comparator flags, synchronous single bits
	input wire sense_below_ucp,
	input wire highside_peak_oc,
	input wire avg_above_145pct,
	input wire avg_above_5a,
	input wire fb_above_104pct,
	input wire fb_below_102pct,
	input wire fb_below_3v6,
	input wire fb_below_2v5,
	input wire fb_above_2v7,
	input wire temp_above_155c,
	input wire temp_below_135c,
	// Supply and detect flags
	input wire supply_above_4v5,
	input wire supply_below_4v,
	input wire detect_above_0v6,
	input wire detect_above_2v4,
	input wire bus_bias_above_2v5,
	input wire ref_regulated,
	input wire charge_enable,
	input wire monitor_below_threshold,
	input wire other_ok,
	// Register port from the bus logic
	input wire reg_wr,
	input wire [7:0] reg_addr,
	input wire [15:0] reg_wdata,
	input wire voltage_cmd_wr,
	input wire voltage_in_range,
	input wire input_limit_in_range,
	output reg [15:0] reg_rdata,
	// Drive and status outputs
	output wire lowside_gate,
	output wire highside_gate,
	output reg discharge_sink_en,
	output reg ref_supply_en,
	output reg gate_drive_supply_en,
	output reg monitor_active,
	output reg bus_accept,
	output wire input_current_alarm_o,
	output reg input_current_alarm_oe,
	output wire adapter_good_o,
	output reg adapter_good_oe,
	output reg battery_short,
	output reg thermal_shutdown,
	output reg timed_out,
	output reg [15:0] current_limit_ma
);
	localparam ST_IDLE = 2'd0;
	localparam ST_PAUSE = 2'd1;
	localparam ST_RAMP = 2'd2;
	localparam ST_RUN = 2'd3;
	reg [1:0] state_q;
	reg [15:0] chg_current_q;
	reg ls_latch_q, hs_latch_q, ov_q, trickle_q, got_v_q, got_i_q;
	reg [3:0] step_q;
	reg charging;
	wire cur_in_range;
	wire chg_ok;
	wire [15:0] target;
	wire [16:0] ramp_prod;
	wire pause_done, step_done, tmo_done;
	wire cur_wr;
	function in_range;
		input [15:0] v;
		begin
			in_range = (v >= `CPS_CHG_CURRENT_MIN) && (v <= `CPS_CHG_CURRENT_MAX);
		end
	endfunction
	assign cur_wr = reg_wr && (reg_addr == `CPS_OFF_CHG_CURRENT);
	assign cur_in_range = in_range(chg_current_q);
	assign chg_ok = charge_enable && gate_drive_supply_en && !thermal_shutdown && !timed_out &&
		cur_in_range && voltage_in_range && input_limit_in_range && other_ok && !ov_q;
	assign target = trickle_q ? `CPS_TRICKLE_MA : chg_current_q;
	assign ramp_prod = {1'b0, target} * {13'd0, step_q} / 17'd8;
	// Register and status flops
	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			chg_current_q <= `CPS_CHG_CURRENT_RST;
			reg_rdata <= 16'h0000;
			ls_latch_q <= 1'b0;
			hs_latch_q <= 1'b0;
			ov_q <= 1'b0;
			thermal_shutdown <= 1'b0;
			trickle_q <= 1'b0;
			got_v_q <= 1'b0;
			got_i_q <= 1'b0;
			timed_out <= 1'b0;
			discharge_sink_en <= 1'b0;
			ref_supply_en <= 1'b0;
			gate_drive_supply_en <= 1'b0;
			monitor_active <= 1'b0;
			bus_accept <= 1'b0;
			input_current_alarm_oe <= 1'b0;
			adapter_good_oe <= 1'b1;
			current_limit_ma <= 16'h0000;
		end else begin
			bus_accept <= bus_bias_above_2v5 && ref_regulated;
			if (cur_wr && bus_accept)
				chg_current_q <= reg_wdata;
			reg_rdata <= (reg_addr == `CPS_OFF_CHG_CURRENT) ? chg_current_q : 16'h0000;
			if (sense_below_ucp && lowside_on_req)
				ls_latch_q <= 1'b1;
			else if (cycle_start)
				ls_latch_q <= 1'b0;
			if (highside_peak_oc)
				hs_latch_q <= 1'b1;
			else if (cycle_start)
				hs_latch_q <= 1'b0;
			if (fb_above_104pct)
				ov_q <= 1'b1;
			else if (fb_below_102pct)
				ov_q <= 1'b0;
			if (temp_above_155c)
				thermal_shutdown <= 1'b1;
			else if (temp_below_135c)
				thermal_shutdown <= 1'b0;
			if (fb_below_2v5 && state_q == ST_PAUSE && pause_done)
				trickle_q <= 1'b1;
			else if (fb_above_2v7)
				trickle_q <= 1'b0;
			if (tmo_done) begin
				timed_out <= 1'b1;
				got_v_q <= 1'b0;
				got_i_q <= 1'b0;
			end else if (timed_out) begin
				if (voltage_cmd_wr && bus_accept)
					got_v_q <= 1'b1;
				if (cur_wr && bus_accept)
					got_i_q <= 1'b1;
				if (got_v_q && got_i_q)
					timed_out <= 1'b0;
			end
			discharge_sink_en <= charging;
			if (supply_below_4v)
				ref_supply_en <= 1'b0;
			else if (supply_above_4v5 && detect_above_0v6)
				ref_supply_en <= 1'b1;
			gate_drive_supply_en <= supply_above_4v5 && detect_above_2v4 && charge_enable &&
				!thermal_shutdown && !(temp_above_155c);
			monitor_active <= supply_above_4v5 && detect_above_0v6;
			input_current_alarm_oe <= !monitor_below_threshold;
			adapter_good_oe <= !detect_above_2v4;
			current_limit_ma <= (state_q == ST_RAMP) ? ramp_prod[15:0] :
				(state_q == ST_RUN) ? target : 16'h0000;
		end
	end
	assign input_current_alarm_o = 1'b0;
	assign adapter_good_o = 1'b0;
	// Charge sequence: pause on short, ramp, run
	always @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= ST_IDLE;
			step_q <= 4'h0;
			battery_short <= 1'b0;
		end else begin
			case (state_q)
				ST_IDLE: begin
					step_q <= 4'h1;
					if (chg_ok)
						state_q <= ST_RAMP;
				end
				ST_PAUSE: begin
					if (pause_done) begin
						battery_short <= 1'b0;
						step_q <= 4'h1;
						state_q <= ST_RAMP;
					end
				end
				ST_RAMP, ST_RUN: begin
					if (!chg_ok) begin
						state_q <= ST_IDLE;
					end else if (fb_below_3v6) begin
						battery_short <= 1'b1;
						state_q <= ST_PAUSE;
					end else if (state_q == ST_RAMP && step_done) begin
						if (step_q == `CPS_SS_STEPS)
							state_q <= ST_RUN;
						else
							step_q <= step_q + 4'h1;
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end
	always @* begin
		charging = (state_q == ST_RAMP) || (state_q == ST_RUN);
	end
	assign lowside_gate = charging && !ov_q && lowside_on_req && !ls_latch_q;
	assign highside_gate = charging && !ov_q && highside_on_req && !hs_latch_q && !highside_peak_oc &&
		!((chg_current_q < `CPS_LOW_LIMIT_MA) ? avg_above_5a : avg_above_145pct);
	cps_step_timer u_pause (
		.mclk(mclk),
		.rst_b(rst_b),
		.start(charging && chg_ok && fb_below_3v6),
		.load_val(SHORT_PAUSE_CYC[39:0]),
		.running_q(),
		.done_q(pause_done)
	);
	cps_step_timer u_step (
		.mclk(mclk),
		.rst_b(rst_b),
		.start((state_q != ST_RAMP) || (step_done && step_q != `CPS_SS_STEPS)),
		.load_val(SS_STEP_CYC[39:0]),
		.running_q(),
		.done_q(step_done)
	);
	cps_step_timer u_tmo (
		.mclk(mclk),
		.rst_b(rst_b),
		.start(bus_accept && (voltage_cmd_wr || cur_wr)),
		.load_val(TIMEOUT_CYC),
		.running_q(),
		.done_q(tmo_done)
	);
endmodule

// ### cps_sup_asserts.sv
// Checker on the supervisor ports
`timescale 1ns/10ps
module cps_sup_asserts (
	// Clock and reset
	input wire mclk, rst_b, cycle_start,
	// Flags
	input wire lowside_on_req, highside_on_req, sense_below_ucp, highside_peak_oc, avg_above_145pct, avg_above_5a,
	input wire fb_above_104pct, detect_above_2v4, monitor_below_threshold, bus_bias_above_2v5, ref_regulated,
	// Outputs
	input wire lowside_gate, highside_gate, adapter_good_oe, input_current_alarm_oe, thermal_shutdown,
	input wire gate_drive_supply_en, bus_accept
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	chk_lowside_latch: assert property (sense_below_ucp && lowside_on_req ##1 !cycle_start |-> !lowside_gate)
		else $error("low side on while latched");
	chk_highside_latch: assert property (highside_peak_oc && highside_on_req ##1 !cycle_start |-> !highside_gate)
		else $error("high side on while latched");
	chk_avg_over: assert property ((avg_above_145pct && avg_above_5a) [*2] |-> !highside_gate)
		else $error("high side on above average limit");
	chk_over_volt: assert property (fb_above_104pct |=> !highside_gate && !lowside_gate)
		else $error("switching above voltage limit");
	chk_adapter_good: assert property ($stable(detect_above_2v4) [*2] |-> adapter_good_oe == !detect_above_2v4)
		else $error("adapter good wrong");
	chk_input_alarm: assert property (monitor_below_threshold [*2] |-> !input_current_alarm_oe)
		else $error("input alarm pulled low");
	chk_thermal_gate: assert property (thermal_shutdown [*2] |-> !gate_drive_supply_en)
		else $error("gate supply on when hot");
	chk_bus_gate: assert property (bus_accept |-> $past(bus_bias_above_2v5 && ref_regulated))
		else $error("bus accepted without bias");
endmodule
bind cps_supervisor cps_sup_asserts chk_u (.*);

// ### cps_host_model.sv
// Host model that programs the supervisor
`timescale 1ns/10ps
module cps_host_model (
	// Clock
	input wire mclk,
	// Register port
	input wire [15:0] reg_rdata,
	output reg reg_wr,
	output reg [7:0] reg_addr,
	output reg [15:0] reg_wdata,
	output reg voltage_cmd_wr
);
	initial begin
		reg_wr = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 16'h0000;
		voltage_cmd_wr = 1'b0;
	end
	task wr(input [7:0] a, input [15:0] d);
		@(negedge mclk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge mclk);
		reg_wr = 1'b0;
		reg_wdata = ~d;
	endtask
	task vcmd;
		@(negedge mclk);
		voltage_cmd_wr = 1'b1;
		@(negedge mclk);
		voltage_cmd_wr = 1'b0;
	endtask
	task rd(input [7:0] a, output [15:0] d);
		@(negedge mclk);
		reg_addr = a;
		@(negedge mclk);
		d = reg_rdata;
	endtask
endmodule

// ### tb.sv
// Testbench for the charger protection supervisor
`timescale 1ns/10ps
module tb;
	logic mclk, rst_b, cycle_start, lowside_on_req, highside_on_req, sense_below_ucp, highside_peak_oc;
	logic avg_above_145pct, avg_above_5a, fb_above_104pct, fb_below_102pct, fb_below_3v6, fb_below_2v5;
	logic fb_above_2v7, temp_above_155c, temp_below_135c, supply_above_4v5, supply_below_4v, detect_above_0v6;
	logic detect_above_2v4, bus_bias_above_2v5, ref_regulated, charge_enable, monitor_below_threshold, other_ok;
	logic reg_wr, voltage_cmd_wr, voltage_in_range, input_limit_in_range, lowside_gate, highside_gate;
	logic discharge_sink_en, ref_supply_en, gate_drive_supply_en, monitor_active, bus_accept;
	logic input_current_alarm_o, input_current_alarm_oe, adapter_good_o, adapter_good_oe;
	logic battery_short, thermal_shutdown, timed_out;
	logic [7:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, current_limit_ma, rv;
	int bad_count = 0;
	int n_checks = 0;
	cps_supervisor #(.SHORT_PAUSE_CYC(40'd20), .SS_STEP_CYC(40'd20), .TIMEOUT_CYC(40'd600)) dut_u (.*);
	cps_host_model host_u (.*);
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	task complete_run;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task chk(input [15:0] seen, input [15:0] exp, input string nm);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(negedge mclk);
	endtask
	initial begin
		#16000;
		bad_count++;
		complete_run;
	end
	initial begin
		{cycle_start, lowside_on_req, highside_on_req, sense_below_ucp, highside_peak_oc, avg_above_145pct} = '0;
		{avg_above_5a, fb_above_104pct, fb_below_3v6, fb_below_2v5, temp_above_155c, supply_below_4v} = '0;
		{fb_below_102pct, fb_above_2v7, temp_below_135c, supply_above_4v5, detect_above_0v6, detect_above_2v4} = '1;
		{bus_bias_above_2v5, ref_regulated, charge_enable, monitor_below_threshold, other_ok} = '1;
		{voltage_in_range, input_limit_in_range} = '1;
		rst_b = 1'b0;
		cyc(6);
		chk(adapter_good_oe, 1, "reset adapter good");
		rst_b = 1'b1;
		cyc(3);
		chk({adapter_good_oe, input_current_alarm_oe}, 0, "status");
		chk({ref_supply_en, monitor_active, bus_accept}, 3'b111, "supplies");
		host_u.wr(8'h14, 16'h03E8);
		host_u.vcmd();
		host_u.rd(8'h14, rv);
		chk(rv, 16'h03E8, "current reg");
		host_u.rd(8'h15, rv);
		chk(rv, 16'h0000, "unmapped");
		cyc(190);
		chk(current_limit_ma, 16'h03E8, "ramp");
		chk({discharge_sink_en, gate_drive_supply_en}, 2'b11, "charging");
		lowside_on_req = 1'b1;
		sense_below_ucp = 1'b1;
		cyc(1);
		sense_below_ucp = 1'b0;
		cyc(1);
		chk(lowside_gate, 0, "low side latched");
		cycle_start = 1'b1;
		cyc(1);
		cycle_start = 1'b0;
		chk(lowside_gate, 1, "low side cleared");
		lowside_on_req = 1'b0;
		{fb_below_3v6, fb_below_2v5, fb_above_2v7} = 3'b110;
		cyc(1);
		chk(battery_short, 1, "short");
		fb_below_3v6 = 1'b0;
		cyc(200);
		chk(current_limit_ma, 16'h00DC, "trickle");
		{fb_below_2v5, fb_above_2v7} = 2'b01;
		cyc(4);
		chk(current_limit_ma, 16'h03E8, "after trickle");
		cyc(600);
		chk({timed_out, discharge_sink_en}, 2'b10, "timeout");
		host_u.wr(8'h14, 16'h03E8);
		cyc(2);
		chk(timed_out, 1, "one command");
		host_u.vcmd();
		cyc(2);
		chk(timed_out, 0, "both commands");
		{temp_above_155c, temp_below_135c} = 2'b10;
		cyc(3);
		chk({thermal_shutdown, gate_drive_supply_en}, 2'b10, "hot");
		temp_above_155c = 1'b0;
		cyc(3);
		chk(thermal_shutdown, 1, "hysteresis");
		temp_below_135c = 1'b1;
		cyc(3);
		chk({thermal_shutdown, gate_drive_supply_en}, 2'b01, "cooled");
		highside_on_req = 1'b1;
		avg_above_145pct = 1'b1;
		cyc(2);
		chk(highside_gate, 1, "low limit uses fixed level");
		avg_above_5a = 1'b1;
		cyc(1);
		chk(highside_gate, 0, "average over");
		{avg_above_145pct, avg_above_5a} = 2'b00;
		cyc(1);
		chk(highside_gate, 1, "average resume");
		highside_peak_oc = 1'b1;
		cyc(1);
		highside_peak_oc = 1'b0;
		cyc(1);
		chk(highside_gate, 0, "high side latched");
		cycle_start = 1'b1;
		cyc(1);
		cycle_start = 1'b0;
		chk(highside_gate, 1, "high side cleared");
		{fb_above_104pct, fb_below_102pct} = 2'b10;
		cyc(1);
		fb_above_104pct = 1'b0;
		cyc(2);
		chk(highside_gate, 0, "over voltage hold");
		fb_below_102pct = 1'b1;
		cyc(3);
		chk(highside_gate, 1, "over voltage resume");
		highside_on_req = 1'b0;
		bus_bias_above_2v5 = 1'b0;
		cyc(2);
		host_u.wr(8'h14, 16'h0100);
		bus_bias_above_2v5 = 1'b1;
		cyc(2);
		host_u.rd(8'h14, rv);
		chk(rv, 16'h03E8, "refused");
		host_u.wr(8'h14, 16'h0010);
		cyc(3);
		chk(discharge_sink_en, 0, "range");
		monitor_below_threshold = 1'b0;
		detect_above_2v4 = 1'b0;
		cyc(3);
		chk({input_current_alarm_oe, adapter_good_oe, gate_drive_supply_en}, 3'b110, "alarms");
		chk({input_current_alarm_o, adapter_good_o}, 2'b00, "pin levels");
		complete_run;
	end
endmodule
